// ===== core/wcaf_pkg.sv
// Package with register map, field layout, reset values and carrier types of the window comparator alert block.
package wcaf_pkg;
    localparam int          WCAF_NCHAN        = 2;
    localparam int          WCAF_CODE_W       = 12;
    localparam int          WCAF_CNT_W        = 5;
    localparam int          WCAF_BUF_DEPTH    = 16;
    localparam int          WCAF_PTR_W        = 4;
    localparam logic [7:0]  WCAF_ADDR_HIFLAG  = 8'h0E;
    localparam logic [7:0]  WCAF_ADDR_EVCNT   = 8'h36;
    localparam logic [7:0]  WCAF_ADDR_BUF_HI  = 8'h50;
    localparam logic [7:0]  WCAF_ADDR_BUF_LO  = 8'h51;
    localparam logic [7:0]  WCAF_ADDR_STATUS  = 8'h52;
    localparam logic [7:0]  WCAF_CLR_ALL      = 8'hFF;
    localparam logic [1:0]  WCAF_FLAG_RST     = 2'h0;
    localparam logic [3:0]  WCAF_EVCNT_RST    = 4'h0;
    localparam int          WCAF_EVCNT_LSB    = 4;
    localparam logic [7:0]  WCAF_RD_UNMAPPED  = 8'h00;
    localparam logic [11:0] WCAF_CODE_MIN     = 12'h000;
    localparam logic [11:0] WCAF_CODE_MAX     = 12'hFFF;

    typedef struct packed {
        logic        chan;
        logic [11:0] code;
    } wcaf_sample_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wcaf_reg_req_t;
endpackage

// ===== core/wcaf_top.sv
// Window comparator alert logic with latched high-side flags, event counter and sample buffer.
// Summary of operation
// - One sticky high-side flag per channel, channel 0 bit 0, channel 1 bit 1.
// - Power-up and general-call software reset clear all high-side flags.
// - Writing FFh to the high flag register clears both flags together.
// - Writing one to a flag bit clears that flag only.
// - Flag register bits 7 to 2 always read zero.
// - Flag one means high-side alert recorded; zero means none.
// - Low-side comparator asserts when result is at or below low threshold.
// - High-side comparator asserts when result is at or above high threshold.
// - High threshold FFFh makes the high comparator fire only at full scale.
// - Low threshold 000h makes the low comparator fire only at zero.
// - Alert output rises when the signal crosses either threshold.
// - Sixteen samples are buffered for the host to read after an alert.
// - Consecutive conversions needed equals the count field plus one.
// - Alert waits until the comparator stays set for that many conversions.
`timescale 1ns/100ps
module wcaf_top (
    input  wire logic                                    ref_clk_i,
    input  wire logic                                    rst_b_i,
    input  wire logic                                    gc_reset_i,
    input  wire wcaf_pkg::wcaf_reg_req_t                 reg_req_i,
    input  wire logic                                    conv_valid_i,
    input  wire wcaf_pkg::wcaf_sample_t                  conv_i,
    input  wire logic [1:0][wcaf_pkg::WCAF_CODE_W-1:0]   low_thresh_i,
    input  wire logic [1:0][wcaf_pkg::WCAF_CODE_W-1:0]   high_thresh_i,
    output logic [7:0]                                   reg_rdata_o,
    output logic                                         alert_o
);
    import wcaf_pkg::*;

    function automatic logic [WCAF_CNT_W-1:0] cnt_step(input logic [WCAF_CNT_W-1:0] cnt,
                                                        input logic [WCAF_CNT_W-1:0] target);
        // Clamping to the target keeps a lowered count field from leaving a counter above it.
        cnt_step = (cnt >= target) ? target : WCAF_CNT_W'(cnt + 1'b1);
    endfunction

    logic [1:0]                 flags_q;
    logic [1:0]                 flags_d;
    logic [1:0]                 low_seen_q;
    logic [3:0]                 evcnt_q;
    logic [WCAF_CNT_W-1:0]      hi_cnt_q [WCAF_NCHAN];
    logic [WCAF_CNT_W-1:0]      lo_cnt_q [WCAF_NCHAN];
    logic [1:0]                 hi_hit;
    logic [1:0]                 lo_hit;
    logic [1:0]                 hi_evt;
    logic [1:0]                 lo_evt;
    logic [WCAF_CNT_W-1:0]      target;
    logic                       wr_flag;
    logic                       wr_evcnt;
    logic [1:0]                 clr_mask;
    logic                       any_evt;
    logic [WCAF_CODE_W:0]       buf_mem [WCAF_BUF_DEPTH];
    logic [WCAF_PTR_W-1:0]      wr_ptr_q;
    logic [WCAF_PTR_W-1:0]      rd_ptr_q;
    logic                       frozen_q;
    logic [WCAF_CODE_W:0]       buf_word;
    logic [7:0]                 rd_mux;

    // Count target is the field value plus one, so zero means a single conversion.
    assign target   = WCAF_CNT_W'({1'b0, evcnt_q}) + WCAF_CNT_W'(1);
    assign wr_flag  = reg_req_i.wr && (reg_req_i.addr == WCAF_ADDR_HIFLAG);
    assign wr_evcnt = reg_req_i.wr && (reg_req_i.addr == WCAF_ADDR_EVCNT);
    // An FFh write is simply every bit written as one, so both flags go at once.
    assign clr_mask = wr_flag ? reg_req_i.wdata[1:0] : 2'h0;
    assign any_evt  = |hi_evt || |lo_evt;

    genvar c;
    generate
        for (c = 0; c < WCAF_NCHAN; c++) begin : g_chan
            logic mine;
            assign mine      = conv_valid_i && (conv_i.chan == 1'(c));
            assign hi_hit[c] = conv_i.code >= high_thresh_i[c];
            assign lo_hit[c] = conv_i.code <= low_thresh_i[c];
            assign hi_evt[c] = mine && hi_hit[c] && (cnt_step(hi_cnt_q[c], target) >= target);
            assign lo_evt[c] = mine && lo_hit[c] && (cnt_step(lo_cnt_q[c], target) >= target);

            always_ff @(posedge ref_clk_i) begin
                if (!rst_b_i || gc_reset_i) begin
                    hi_cnt_q[c] <= '0;
                    lo_cnt_q[c] <= '0;
                end else if (mine) begin
                    // A conversion on this channel that misses the comparator breaks the run and restarts the count.
                    hi_cnt_q[c] <= hi_hit[c] ? cnt_step(hi_cnt_q[c], target) : '0;
                    lo_cnt_q[c] <= lo_hit[c] ? cnt_step(lo_cnt_q[c], target) : '0;
                end
            end
        end
    endgenerate

    // A new event wins over a clear that lands in the same cycle.
    assign flags_d = (flags_q & ~clr_mask) | hi_evt;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || gc_reset_i) begin
            flags_q    <= WCAF_FLAG_RST;
            low_seen_q <= WCAF_FLAG_RST;
            alert_o    <= 1'b0;
        end else begin
            flags_q    <= flags_d;
            // The low side has no flag register here, so its record only ends at reset.
            low_seen_q <= low_seen_q | lo_evt;
            alert_o    <= (|flags_d) || (|low_seen_q) || (|lo_evt);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            evcnt_q <= WCAF_EVCNT_RST;
        end else if (wr_evcnt) begin
            evcnt_q <= reg_req_i.wdata[WCAF_EVCNT_LSB +: 4];
        end
    end

    // The buffer runs as a ring until the alerting sample, which is kept as its last entry.
    always_ff @(posedge ref_clk_i) begin
        if (conv_valid_i && !frozen_q) begin
            buf_mem[wr_ptr_q] <= {conv_i.chan, conv_i.code};
        end
    end

    assign buf_word = buf_mem[rd_ptr_q];

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || gc_reset_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            frozen_q <= 1'b0;
        end else if (conv_valid_i && !frozen_q) begin
            wr_ptr_q <= WCAF_PTR_W'(wr_ptr_q + 1'b1);
            frozen_q <= any_evt;
            rd_ptr_q <= WCAF_PTR_W'(wr_ptr_q + 1'b1);
        end else if (reg_req_i.rd && reg_req_i.addr == WCAF_ADDR_BUF_LO) begin
            rd_ptr_q <= WCAF_PTR_W'(rd_ptr_q + 1'b1);
        end
    end

    always_comb begin
        case (reg_req_i.addr)
            WCAF_ADDR_HIFLAG: rd_mux = {6'h00, flags_q};
            WCAF_ADDR_EVCNT:  rd_mux = {evcnt_q, 4'h0};
            WCAF_ADDR_BUF_HI: rd_mux = {buf_word[WCAF_CODE_W], 3'h0, buf_word[11:8]};
            WCAF_ADDR_BUF_LO: rd_mux = buf_word[7:0];
            WCAF_ADDR_STATUS: rd_mux = {frozen_q, 5'h00, low_seen_q};
            default:          rd_mux = WCAF_RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_req_i.rd) begin
            reg_rdata_o <= rd_mux;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_flag_read;
        reg_req_i.rd && reg_req_i.addr == WCAF_ADDR_HIFLAG;
    endsequence

    property p_reserved_zero;
        s_flag_read |=> reg_rdata_o[7:2] == 6'h00 && reg_rdata_o[1:0] == $past(flags_q);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bits not zero");

    property p_w1c;
        wr_flag && reg_req_i.wdata[0] && !hi_evt[0] && !gc_reset_i |=> !flags_q[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear flag 0");

    property p_clear_all;
        wr_flag && reg_req_i.wdata == WCAF_CLR_ALL && hi_evt == 2'h0 |=> flags_q == 2'h0;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("FFh write did not clear flags");

    property p_gc_clear;
        gc_reset_i |=> flags_q == 2'h0 && !alert_o;
    endproperty
    a_gc_clear: assert property (p_gc_clear) else $error("general call did not clear flags");

    property p_sticky;
        flags_q[1] && !(wr_flag && reg_req_i.wdata[1]) && !gc_reset_i |=> flags_q[1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag 1 dropped without a clear");

    property p_flag_cause;
        $rose(flags_q[0]) |-> $past(conv_valid_i && !conv_i.chan && conv_i.code >= high_thresh_i[0]);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag 0 set without high hit");

    property p_count_reached;
        $rose(flags_q[1]) |-> $past(cnt_step(hi_cnt_q[1], target)) == $past(target);
    endproperty
    a_count_reached: assert property (p_count_reached) else $error("flag set before count reached");

    property p_low_hit;
        conv_valid_i && conv_i.code <= low_thresh_i[conv_i.chan] |-> lo_hit[conv_i.chan];
    endproperty
    a_low_hit: assert property (p_low_hit) else $error("low comparator missed");

    property p_alert_cause;
        $rose(alert_o) |-> $past(any_evt);
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert rose without an event");

    // The general call is left out of the antecedent, so one that unfreezes the ring is never flagged.
    property p_freeze;
        frozen_q && !gc_reset_i |=> frozen_q && $stable(wr_ptr_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("buffer moved while frozen");

    // Alert is a level towards the host, so only a flag write or a reset may drop it.
    property p_alert_hold;
        alert_o && !wr_flag && !gc_reset_i |=> alert_o;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert dropped without a clear");

    property p_buf_advance;
        frozen_q && reg_req_i.rd && reg_req_i.addr == WCAF_ADDR_BUF_LO && !gc_reset_i
            |=> rd_ptr_q == WCAF_PTR_W'($past(rd_ptr_q) + 1'b1);
    endproperty
    a_buf_advance: assert property (p_buf_advance) else $error("buffer read pointer did not advance");
endmodule

// ===== sim/wcaf_host_model.sv
// Host model that issues decoded register reads and writes to the alert block.
`timescale 1ns/100ps
module wcaf_host_model (
    input  wire logic              ref_clk_i,
    input  wire logic [7:0]        reg_rdata_i,
    output wcaf_pkg::wcaf_reg_req_t reg_req_o
);
    import wcaf_pkg::*;
    initial reg_req_o = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk_i);
        reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk_i);
        reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        d = reg_rdata_i;
    endtask
endmodule

// ===== sim/wcaf_top_test.sv
// Self-checking bench for the window comparator alert block.
`timescale 1ns/100ps
module wcaf_top_test;
    import wcaf_pkg::*;
    typedef struct packed {logic ch; logic [11:0] code; logic [7:0] flags;} wcaf_row_t;
    localparam wcaf_row_t ROWS [4] = '{'{1'b0, 12'h31F, 8'h00}, '{1'b1, 12'hFFE, 8'h00},
                                      '{1'b0, 12'h320, 8'h01}, '{1'b1, 12'hFFF, 8'h03}};
    logic                        ref_clk_i, rst_b_i, gc_reset_i, conv_valid_i, alert_o;
    wcaf_sample_t                conv_i;
    wcaf_reg_req_t               reg_req;
    logic [1:0][WCAF_CODE_W-1:0] low_thresh_i, high_thresh_i;
    logic [7:0]                  reg_rdata;
    int                          fail_count = 0;
    int                          tests_run = 0;

    wcaf_top i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .gc_reset_i(gc_reset_i),
        .reg_req_i(reg_req), .conv_valid_i(conv_valid_i), .conv_i(conv_i),
        .low_thresh_i(low_thresh_i), .high_thresh_i(high_thresh_i),
        .reg_rdata_o(reg_rdata), .alert_o(alert_o));
    wcaf_host_model i_host (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata), .reg_req_o(reg_req));

    task automatic give_verdict;
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic conv(input logic ch, input logic [11:0] code);
        @(negedge ref_clk_i);
        conv_valid_i = 1'b1;
        conv_i = '{chan: ch, code: code};
        @(negedge ref_clk_i);
        conv_valid_i = 1'b0;
        conv_i = '{chan: ~ch, code: ~code};
    endtask
    task automatic pulse_gc;
        @(negedge ref_clk_i);
        gc_reset_i = 1'b1;
        @(negedge ref_clk_i);
        gc_reset_i = 1'b0;
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    // Whole run is under two hundred cycles, so 5000 cycles means a hang.
    initial begin
        #200000;
        fail_count++;
        give_verdict;
    end

    initial begin
        rst_b_i = 1'b0;
        gc_reset_i = 1'b0;
        conv_valid_i = 1'b0;
        conv_i = '0;
        low_thresh_i = {12'h000, 12'h064};
        high_thresh_i = {12'hFFF, 12'h320};
        repeat (20) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        rdchk(WCAF_ADDR_HIFLAG, 8'h00);
        foreach (ROWS[i]) begin
            conv(ROWS[i].ch, ROWS[i].code);
            rdchk(WCAF_ADDR_HIFLAG, ROWS[i].flags);
            chk({7'h0, alert_o}, {7'h0, |ROWS[i].flags});
        end
        i_host.wr(WCAF_ADDR_HIFLAG, 8'hFE);
        rdchk(WCAF_ADDR_HIFLAG, 8'h01);
        i_host.wr(WCAF_ADDR_HIFLAG, WCAF_CLR_ALL);
        rdchk(WCAF_ADDR_HIFLAG, 8'h00);
        chk({7'h0, alert_o}, 8'h00);
        conv(1'b1, 12'h001);
        chk({7'h0, alert_o}, 8'h00);
        conv(1'b0, 12'h064);
        chk({7'h0, alert_o}, 8'h01);
        rdchk(WCAF_ADDR_STATUS, 8'h81);
        rdchk(8'h7F, WCAF_RD_UNMAPPED);
        pulse_gc;
        chk({7'h0, alert_o}, 8'h00);
        i_host.wr(WCAF_ADDR_EVCNT, 8'h20);
        rdchk(WCAF_ADDR_EVCNT, 8'h20);
        repeat (2) conv(1'b0, 12'h320);
        conv(1'b0, 12'h31F);
        repeat (2) conv(1'b0, 12'h320);
        rdchk(WCAF_ADDR_HIFLAG, 8'h00);
        conv(1'b0, 12'h320);
        rdchk(WCAF_ADDR_HIFLAG, 8'h01);
        @(negedge ref_clk_i);
        rst_b_i = 1'b0;
        @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        rdchk(WCAF_ADDR_HIFLAG, 8'h00);
        rdchk(WCAF_ADDR_EVCNT, 8'h00);
        // Fifteen quiet samples, then the alerting one, which must sit last in the frozen ring.
        for (int k = 0; k < 15; k++) begin
            conv(1'b0, 12'h100 + 12'(k));
        end
        conv(1'b1, WCAF_CODE_MAX);
        chk({7'h0, alert_o}, 8'h01);
        for (int k = 0; k < WCAF_BUF_DEPTH; k++) begin
            rdchk(WCAF_ADDR_BUF_HI, (k == 15) ? 8'h8F : 8'h01);
            rdchk(WCAF_ADDR_BUF_LO, (k == 15) ? 8'hFF : 8'(k));
        end
        rdchk(WCAF_ADDR_HIFLAG, 8'h02);
        give_verdict;
    end
endmodule
